/* pfs_pkg.sv */
// shared constants for the power fault supervisor
package pfs_pkg;
    // clock and debounce timing
    localparam int CLK_FREQ_KHZ     = 250_000;
    localparam int OV_DEBOUNCE_MS   = 30;
    localparam int OC_DEBOUNCE_MS   = 60;
    localparam int OV_DEBOUNCE_CYC  = OV_DEBOUNCE_MS * CLK_FREQ_KHZ;
    localparam int OC_DEBOUNCE_CYC  = OC_DEBOUNCE_MS * CLK_FREQ_KHZ;

    // measurement codes
    localparam int              MEAS_W       = 16;
    localparam logic [15:0]     FULL_SCALE_V = 16'h2710;
    localparam logic [15:0]     FULL_SCALE_I = 16'h2710;
    // trip ceiling is 110 percent of full scale
    localparam logic [15:0]     OV_TRIP_MAX  = FULL_SCALE_V + FULL_SCALE_V / 16'h000A;
    localparam logic [15:0]     OC_TRIP_MAX  = FULL_SCALE_I + FULL_SCALE_I / 16'h000A;

    // register byte addresses
    localparam logic [7:0]      ADDR_CTRL    = 8'h00;
    localparam logic [7:0]      ADDR_OVT     = 8'h04;
    localparam logic [7:0]      ADDR_OCT     = 8'h08;
    localparam logic [7:0]      ADDR_STATUS  = 8'h0C;

    // control register fields
    localparam int              CTRL_START   = 0;
    localparam int              CTRL_STOP    = 1;
    localparam int              CTRL_CLEAR   = 2;
    localparam int              CTRL_ILOCK   = 3;
    localparam int              CTRL_INT     = 4;
    localparam int              CTRL_EXT     = 5;
    localparam logic [31:0]     CTRL_RESET   = 32'h00000030;

    // fault bit positions, also status bits 5..0
    localparam int              NFAULT       = 6;
    localparam int              F_OV         = 0;
    localparam int              F_OC         = 1;
    localparam int              F_TH         = 2;
    localparam int              F_IL         = 3;
    localparam int              F_PH         = 4;
    localparam int              F_PG         = 5;
    localparam int              ST_STATE_LSB = 8;

    typedef enum logic [1:0] {
        PFS_STANDBY = 2'b00,
        PFS_POWERED = 2'b01,
        PFS_ALARM   = 2'b10
    } pfs_state_t;
endpackage : pfs_pkg

/* pfs_debounce.sv */
// continuous-excursion debounce timer
module pfs_debounce #(
    parameter int CYCLES = 4
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // condition in, trip out
    input  wire logic cond,
    output logic      trip
);
    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_reg;
    logic          trip_reg;

    // any gap restarts the count, so only unbroken excursions trip
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (!cond) begin
            cnt_reg <= '0;
        end else if (cnt_reg != CW'(CYCLES)) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trip_reg <= 1'b0;
        end else begin
            trip_reg <= cond && (cnt_reg >= CW'(CYCLES - 1));
        end
    end

    assign trip = trip_reg;
endmodule : pfs_debounce

/* pfs_supervisor.sv */
// power fault supervisor: fault latching, run state and register port
//
// Contract
// - over-voltage registers only after 30 ms continuous excursion above trip setting
// - over-voltage trip setting clamps to 110 percent of full scale voltage
// - over-voltage fault opens contactor, control power stays on
// - latched over-voltage lights indicator, alarm line and status bit
// - over-voltage recovery: voltage below trip, then Clear, then Start
// - over-current registers only after 60 ms continuous excursion above trip
// - over-current trip setting clamps to 110 percent of full scale current
// - both trip settings reset to 110 percent of rating
// - over-current opens contactor, indicator, alarm line and status bit
// - over-current recovery: current below trip, then Clear, then Start
// - thermal fault opens contactor, keeps fans, refuses enables, flags alarms
// - thermal recovery: cool, Clear, Start; starting hot re-enters fault
// - enabled interlock losing its high level switches out dissipative stage
// - interlock disabled at reset, enabled by panel or remote command
// - interlock recovery: input high again, then Clear
// - phase A below 10 percent faults, opens contactor, blocks panel and external enables
// - phase loss in standby still blocks panel and external starts (a remote register Start is not blocked)
// - phase loss shows on indicator and status only, no alarm line
// - phase recovery: line back within 10 percent, Clear, Start
// - analog input over 12.5 V opens contactor and flags alarms
// - analog over-range recovery: inputs below 12.5 V, Clear, Start
// - Clear unlatches a fault only once its condition is resolved
// - Start accepted only in standby
// - Stop overrides all commands; Start during Stop does nothing (here Stop blocks Start only; Clear still acts)
//
// Design decisions made here: the register offsets and strobed register access.
module pfs_supervisor
    import pfs_pkg::*;
#(
    parameter int OV_CYCLES = OV_DEBOUNCE_CYC,
    parameter int OC_CYCLES = OC_DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // measurements and sensors
    input  wire logic [MEAS_W-1:0] v_meas,
    input  wire logic [MEAS_W-1:0] i_meas,
    input  wire logic              heatsink_thermal_fault,
    input  wire logic              safety_chain_input,
    input  wire logic              line_phase_fault,
    input  wire logic              line_within_nominal,
    input  wire logic              analog_program_overrange,
    // front panel
    input  wire logic              panel_start,
    input  wire logic              panel_stop,
    input  wire logic              panel_clear,
    input  wire logic              panel_ilock_on,
    input  wire logic              panel_ilock_off,
    // external control lines
    input  wire logic              ext_start,
    input  wire logic              ext_stop,
    input  wire logic              ext_clear,
    // power stage
    output logic                   contactor_closed,
    output logic                   dissipative_on,
    output logic                   control_power_on,
    output logic                   fan_power_on,
    // indications
    output logic [NFAULT-1:0]      fault_led,
    output logic                   alarm_overvoltage_trip,
    output logic                   alarm_overcurrent_trip,
    output logic                   alarm_heatsink_thermal_fault,
    output logic                   alarm_analog_program_overrange
);
    logic [MEAS_W-1:0] ovt_reg;
    logic [MEAS_W-1:0] oct_reg;
    logic              int_ctl_reg;
    logic              ext_ctl_reg;
    logic              ilock_en_reg;
    logic [NFAULT-1:0] fault_reg;
    logic [NFAULT-1:0] fault_next;
    pfs_state_t        state_reg;
    pfs_state_t        state_next;
    logic [31:0]       rdata_reg;
    logic              contactor_reg;
    logic              dissip_reg;
    logic              pwr_reg;
    logic [NFAULT-1:0] led_reg;
    logic [3:0]        alarm_reg;

    logic              ov_trip;
    logic              oc_trip;
    logic              wr_ctrl;
    logic              reg_start;
    logic              reg_stop;
    logic              reg_clear;
    logic              stop_active;
    logic              start_local;
    logic              start_remote;
    logic              clear_req;
    logic [NFAULT-1:0] fault_set;
    logic [NFAULT-1:0] resolved;
    logic              other_faults;

    // debounced over-limit detection
    pfs_debounce #(.CYCLES(OV_CYCLES)) u_ov_deb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cond    (v_meas > ovt_reg),
        .trip    (ov_trip)
    );

    pfs_debounce #(.CYCLES(OC_CYCLES)) u_oc_deb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cond    (i_meas > oct_reg),
        .trip    (oc_trip)
    );

    // command decode; remote commands count as external control
    assign wr_ctrl      = reg_wr && (reg_addr == ADDR_CTRL);
    assign reg_start    = wr_ctrl && reg_wdata[CTRL_START];
    assign reg_stop     = wr_ctrl && reg_wdata[CTRL_STOP];
    assign reg_clear    = wr_ctrl && reg_wdata[CTRL_CLEAR];
    assign stop_active  = (int_ctl_reg && panel_stop)
                        || (ext_ctl_reg && (ext_stop || reg_stop));
    assign start_local  = (int_ctl_reg && panel_start) || (ext_ctl_reg && ext_start);
    assign start_remote = ext_ctl_reg && reg_start;
    assign clear_req    = (int_ctl_reg && panel_clear) || (ext_ctl_reg && (ext_clear || reg_clear));

    // raw fault causes
    always_comb begin
        fault_set       = '0;
        fault_set[F_OV] = ov_trip;
        fault_set[F_OC] = oc_trip;
        fault_set[F_TH] = heatsink_thermal_fault;
        fault_set[F_IL] = ilock_en_reg && !safety_chain_input;
        fault_set[F_PH] = line_phase_fault;
        fault_set[F_PG] = analog_program_overrange;
    end

    // conditions that let a Clear through
    always_comb begin
        resolved       = '0;
        resolved[F_OV] = !(v_meas > ovt_reg);
        resolved[F_OC] = !(i_meas > oct_reg);
        resolved[F_TH] = !heatsink_thermal_fault;
        resolved[F_IL] = safety_chain_input || !ilock_en_reg;
        resolved[F_PH] = line_within_nominal;
        resolved[F_PG] = !analog_program_overrange;
    end

    // a new event wins over a Clear in the same cycle
    always_comb begin
        fault_next = fault_reg | fault_set;
        for (int i = 0; i < NFAULT; i++) begin
            if (clear_req && resolved[i] && !fault_set[i]) begin
                fault_next[i] = 1'b0;
            end
        end
    end

    assign other_faults = |(fault_next & ~(NFAULT'(1) << F_PH));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PFS_STANDBY: begin
                if (other_faults) begin
                    state_next = PFS_ALARM;
                end else if (stop_active) begin
                    state_next = PFS_STANDBY;
                end else if (start_remote || (start_local && !fault_next[F_PH])) begin
                    state_next = PFS_POWERED;
                end
            end
            PFS_POWERED: begin
                if (|fault_next) begin
                    state_next = PFS_ALARM;
                end else if (stop_active) begin
                    state_next = PFS_STANDBY;
                end
            end
            PFS_ALARM: begin
                // starts are ignored here; leaving needs every fault cleared
                if (fault_next == '0) begin
                    state_next = PFS_STANDBY;
                end
            end
            default: begin
                state_next = PFS_ALARM;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fault_reg <= '0;
            state_reg <= PFS_STANDBY;
        end else begin
            fault_reg <= fault_next;
            state_reg <= state_next;
        end
    end

    // trip settings: writes above the ceiling are pinned to it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ovt_reg <= OV_TRIP_MAX;
            oct_reg <= OC_TRIP_MAX;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_OVT) begin
                ovt_reg <= (reg_wdata[MEAS_W-1:0] > OV_TRIP_MAX)
                         ? OV_TRIP_MAX : reg_wdata[MEAS_W-1:0];
            end
            if (reg_addr == ADDR_OCT) begin
                oct_reg <= (reg_wdata[MEAS_W-1:0] > OC_TRIP_MAX)
                         ? OC_TRIP_MAX : reg_wdata[MEAS_W-1:0];
            end
        end
    end

    // control configuration; interlock off until someone arms it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ilock_en_reg <= CTRL_RESET[CTRL_ILOCK];
            int_ctl_reg  <= CTRL_RESET[CTRL_INT];
            ext_ctl_reg  <= CTRL_RESET[CTRL_EXT];
        end else if (wr_ctrl) begin
            ilock_en_reg <= reg_wdata[CTRL_ILOCK];
            int_ctl_reg  <= reg_wdata[CTRL_INT];
            ext_ctl_reg  <= reg_wdata[CTRL_EXT];
        end else if (panel_ilock_on) begin
            ilock_en_reg <= 1'b1;
        end else if (panel_ilock_off) begin
            ilock_en_reg <= 1'b0;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL: begin
                    rdata_reg <= {26'h0000000, ext_ctl_reg, int_ctl_reg, ilock_en_reg, 3'h0};
                end
                ADDR_OVT: begin
                    rdata_reg <= {16'h0000, ovt_reg};
                end
                ADDR_OCT: begin
                    rdata_reg <= {16'h0000, oct_reg};
                end
                ADDR_STATUS: begin
                    rdata_reg <= {22'h000000, state_reg, 2'h0, fault_reg};
                end
                default: begin
                    rdata_reg <= 32'h00000000;
                end
            endcase
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    // contactor and dissipative stage follow the next state so a fault drops them at once; control power stays on
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            contactor_reg <= 1'b0;
            dissip_reg    <= 1'b0;
            pwr_reg       <= 1'b0;
        end else begin
            contactor_reg <= (state_next == PFS_POWERED);
            dissip_reg    <= (state_next == PFS_POWERED) && !fault_set[F_IL];
            pwr_reg       <= 1'b1;
        end
    end

    // indicators; phase loss has no alarm line of its own
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            led_reg   <= '0;
            alarm_reg <= 4'h0;
        end else begin
            led_reg   <= fault_next;
            alarm_reg <= {fault_next[F_PG], fault_next[F_TH],
                          fault_next[F_OC], fault_next[F_OV]};
        end
    end

    assign reg_rdata                      = rdata_reg;
    assign contactor_closed               = contactor_reg;
    assign dissipative_on                 = dissip_reg;
    assign control_power_on               = pwr_reg;
    assign fan_power_on                   = pwr_reg;
    assign fault_led                      = led_reg;
    assign alarm_overvoltage_trip         = alarm_reg[0];
    assign alarm_overcurrent_trip         = alarm_reg[1];
    assign alarm_heatsink_thermal_fault   = alarm_reg[2];
    assign alarm_analog_program_overrange = alarm_reg[3];

    a_ovt_ceiling: assert property (@(posedge clk_sys) disable iff (rst)
        ovt_reg <= OV_TRIP_MAX) else $error("ov trip setting above ceiling");

    a_oct_ceiling: assert property (@(posedge clk_sys) disable iff (rst)
        oct_reg <= OC_TRIP_MAX) else $error("oc trip setting above ceiling");

    a_fault_opens: assert property (@(posedge clk_sys) disable iff (rst)
        (|fault_set && state_reg == PFS_POWERED) |=> !contactor_closed && state_reg == PFS_ALARM)
        else $error("contactor stayed closed on fault");

    a_ov_indicate: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(fault_reg[F_OV]) |-> alarm_overvoltage_trip && fault_led[F_OV])
        else $error("over-voltage not indicated");

    a_phase_block: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == PFS_STANDBY && fault_reg[F_PH] && !start_remote)
        |=> state_reg != PFS_POWERED) else $error("local start passed phase loss");

    a_alarm_nostart: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == PFS_ALARM |=> state_reg != PFS_POWERED)
        else $error("start left alarm state");

    a_stop_wins: assert property (@(posedge clk_sys) disable iff (rst)
        stop_active |=> state_reg != PFS_POWERED && !contactor_closed)
        else $error("output engaged during stop");

    a_clear_gated: assert property (@(posedge clk_sys) disable iff (rst)
        (fault_reg[F_OV] && !resolved[F_OV]) |=> fault_reg[F_OV])
        else $error("unresolved fault cleared");

    a_ilock_soft: assert property (@(posedge clk_sys) disable iff (rst)
        (ilock_en_reg && !safety_chain_input) |=> !dissipative_on && fault_led[F_IL])
        else $error("interlock loss left dissipative stage on");

    a_latch_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (fault_reg[F_TH] && !clear_req) |=> fault_reg[F_TH] && fault_led[F_TH])
        else $error("thermal fault dropped without clear");
endmodule : pfs_supervisor

/* pfs_partner_model.sv */
// stand-in for the front panel, external control lines and comparators
module pfs_partner_model
    import pfs_pkg::*;
(
    // clock
    input  wire logic              clk_sys,
    // comparator and sensor levels
    output logic [MEAS_W-1:0]      v_meas,
    output logic [MEAS_W-1:0]      i_meas,
    output logic                   heatsink_thermal_fault,
    output logic                   safety_chain_input,
    output logic                   line_phase_fault,
    output logic                   line_within_nominal,
    output logic                   analog_program_overrange,
    // panel and external lines: start, stop, clear, arm, disarm, ext start, stop, clear
    output logic [7:0]             cmd
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        v_meas = 16'h0100;
        i_meas = 16'h0100;
        heatsink_thermal_fault = 1'h0;
        safety_chain_input = 1'h1;
        line_phase_fault = 1'h0;
        line_within_nominal = 1'h1;
        analog_program_overrange = 1'h0;
        cmd = 8'h00;
    end

    // safe levels are restored before the recovering clear; an earlier clear tests the gate
    task automatic sense(input int f, input logic on);
        case (f)
            F_OV: v_meas <= on ? 16'h1001 : 16'h0100;
            F_OC: i_meas <= on ? 16'h0801 : 16'h0100;
            F_TH: heatsink_thermal_fault <= on;
            F_IL: safety_chain_input <= !on;
            F_PH: begin
                line_phase_fault <= on;
                line_within_nominal <= !on;
            end
            default: analog_program_overrange <= on;
        endcase
    endtask : sense

    // one-cycle command pulse, released just after the sampling edge
    task automatic press(input int k);
        cmd[k] <= 1'h1;
        @(posedge clk_sys);
        #1;
        cmd[k] <= 1'h0;
    endtask : press

    // level hold, used for stop
    task automatic hold(input int k, input logic v);
        cmd[k] <= v;
    endtask : hold
endmodule : pfs_partner_model

/* test_power_fault_supervisor.sv */
// self-checking bench for the power fault supervisor
`define CHK(what, exp, got) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end \
end

module test_power_fault_supervisor
    import pfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // short debounce counts keep the run brief
    localparam int OV_C = 8;
    localparam int OC_C = 16;
    localparam int C_PSTART = 0, C_PCLEAR = 2, C_ILON = 3, C_ILOFF = 4;
    localparam int C_XSTART = 5, C_XSTOP = 6, C_XCLEAR = 7;

    logic              clk_sys = 1'h0;
    logic              rst = 1'h1;
    logic [7:0]        reg_addr = 8'h00;
    logic [31:0]       reg_wdata = 32'h0;
    logic              reg_wr = 1'h0;
    logic              reg_rd = 1'h0;
    logic [31:0]       reg_rdata;
    logic [MEAS_W-1:0] v_meas, i_meas;
    logic              thermal, chain, phase, nominal, overrange;
    logic [7:0]        cmd;
    logic              contactor_closed, dissipative_on, control_power_on, fan_power_on;
    logic [NFAULT-1:0] fault_led;
    wire logic [3:0]   alarms;
    logic [31:0]       d;
    int                fails = 0;
    int                n_compared = 0;
    int                cyc = 0;

    typedef struct {
        int         idx;
        logic [3:0] alm;
        int         dly;
    } pfs_row_t;
    // fault, expected alarm lines {program, thermal, current, voltage}, settle cycles
    pfs_row_t rows [5] = '{
        '{F_OV, 4'h1, OV_C + 3},
        '{F_OC, 4'h2, OC_C + 3},
        '{F_TH, 4'h4, 2},
        '{F_PH, 4'h0, 2},
        '{F_PG, 4'h8, 2}
    };

    always #2 clk_sys = ~clk_sys;

    pfs_partner_model pm_u (
        .clk_sys(clk_sys), .v_meas(v_meas), .i_meas(i_meas),
        .heatsink_thermal_fault(thermal), .safety_chain_input(chain),
        .line_phase_fault(phase), .line_within_nominal(nominal),
        .analog_program_overrange(overrange), .cmd(cmd)
    );

    pfs_supervisor #(.OV_CYCLES(OV_C), .OC_CYCLES(OC_C)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .v_meas(v_meas), .i_meas(i_meas), .heatsink_thermal_fault(thermal),
        .safety_chain_input(chain), .line_phase_fault(phase),
        .line_within_nominal(nominal), .analog_program_overrange(overrange),
        .panel_start(cmd[0]), .panel_stop(cmd[1]), .panel_clear(cmd[2]),
        .panel_ilock_on(cmd[3]), .panel_ilock_off(cmd[4]),
        .ext_start(cmd[5]), .ext_stop(cmd[6]), .ext_clear(cmd[7]),
        .contactor_closed(contactor_closed), .dissipative_on(dissipative_on),
        .control_power_on(control_power_on), .fan_power_on(fan_power_on),
        .fault_led(fault_led), .alarm_overvoltage_trip(alarms[0]),
        .alarm_overcurrent_trip(alarms[1]), .alarm_heatsink_thermal_fault(alarms[2]),
        .alarm_analog_program_overrange(alarms[3])
    );

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'h1;
        // strobe drops on the sampling edge, so a following call may raise it again
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        #1;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic wr_rd(input logic [7:0] a, input logic [31:0] w, input logic [31:0] e);
        reg_write(a, w);
        reg_read(a);
        `CHK("register readback", e, d)
    endtask : wr_rd

    initial begin
        tick(2);
        rst <= 1'h0;
        tick(1);
        `CHK("control power", 1'h1, control_power_on)
        `CHK("fan power", 1'h1, fan_power_on)
        reg_read(ADDR_OVT);
        `CHK("ov trip default", 32'h00002AF8, d)
        reg_read(ADDR_OCT);
        `CHK("oc trip default", 32'h00002AF8, d)
        wr_rd(ADDR_OVT, 32'h0000FFFF, 32'h00002AF8);
        wr_rd(ADDR_OCT, 32'h00002AF9, 32'h00002AF8);
        wr_rd(8'h10, 32'h00001234, 32'h00000000);
        wr_rd(ADDR_OVT, 32'h00001000, 32'h00001000);
        wr_rd(ADDR_OCT, 32'h00000800, 32'h00000800);
        foreach (rows[k]) begin
            pm_u.press(C_XSTART);
            tick(1);
            `CHK("started", 1'h1, contactor_closed)
            pm_u.sense(rows[k].idx, 1'h1);
            tick(rows[k].dly);
            `CHK("fault led", 6'(1 << rows[k].idx), fault_led)
            `CHK("contactor open", 1'h0, contactor_closed)
            `CHK("alarm lines", rows[k].alm, alarms)
            `CHK("fan power", 1'h1, fan_power_on)
            pm_u.press(C_PCLEAR);
            tick(1);
            `CHK("clear while active", 6'(1 << rows[k].idx), fault_led)
            pm_u.sense(rows[k].idx, 1'h0);
            tick(2);
            reg_read(ADDR_STATUS);
            `CHK("status latched", 32'h200 | (32'h1 << rows[k].idx), d)
            pm_u.press(C_XSTART);
            tick(1);
            `CHK("start in alarm", 1'h0, contactor_closed)
            pm_u.press(C_XCLEAR);
            tick(1);
            `CHK("cleared", 6'h00, fault_led)
            pm_u.press(C_XSTART);
            tick(1);
            `CHK("restart", 1'h1, contactor_closed)
            reg_write(ADDR_CTRL, CTRL_RESET | 32'h2);
            tick(1);
            `CHK("stopped", 1'h0, contactor_closed)
        end
        // excursion broken one cycle short must not trip
        pm_u.press(C_XSTART);
        tick(1);
        pm_u.sense(F_OV, 1'h1);
        tick(OV_C - 1);
        pm_u.sense(F_OV, 1'h0);
        tick(1);
        pm_u.sense(F_OV, 1'h1);
        tick(OV_C - 1);
        `CHK("broken excursion", 6'h00, fault_led)
        tick(3);
        `CHK("steady excursion", 6'h01, fault_led)
        pm_u.sense(F_OV, 1'h0);
        tick(1);
        pm_u.press(C_PCLEAR);
        tick(1);
        pm_u.hold(C_XSTOP, 1'h1);
        pm_u.press(C_PSTART);
        tick(1);
        `CHK("start under stop", 1'h0, contactor_closed)
        pm_u.hold(C_XSTOP, 1'h0);
        pm_u.sense(F_PH, 1'h1);
        tick(2);
        pm_u.press(C_XSTART);
        pm_u.press(C_PSTART);
        tick(1);
        `CHK("start in phase loss", 1'h0, contactor_closed)
        reg_read(ADDR_STATUS);
        `CHK("phase status", 32'h00000010, d)
        pm_u.sense(F_PH, 1'h0);
        tick(1);
        pm_u.press(C_PCLEAR);
        tick(1);
        // interlock ignored until armed
        pm_u.press(C_XSTART);
        tick(1);
        pm_u.sense(F_IL, 1'h1);
        tick(2);
        `CHK("interlock disarmed", 6'h00, fault_led)
        pm_u.sense(F_IL, 1'h0);
        pm_u.press(C_ILON);
        tick(1);
        `CHK("dissipative in", 1'h1, dissipative_on)
        pm_u.sense(F_IL, 1'h1);
        tick(2);
        `CHK("interlock trip", 6'h08, fault_led)
        `CHK("dissipative out", 1'h0, dissipative_on)
        pm_u.press(C_PCLEAR);
        tick(1);
        `CHK("clear while broken", 6'h08, fault_led)
        pm_u.sense(F_IL, 1'h0);
        tick(1);
        pm_u.press(C_PCLEAR);
        tick(1);
        reg_read(ADDR_STATUS);
        `CHK("interlock recovered", 32'h00000000, d)
        // panel control off: panel start refused, remote start still taken
        reg_write(ADDR_CTRL, 32'h00000020);
        pm_u.press(C_PSTART);
        tick(1);
        `CHK("panel start disabled", 1'h0, contactor_closed)
        reg_write(ADDR_CTRL, 32'h00000021);
        tick(1);
        `CHK("remote start", 1'h1, contactor_closed)
        pm_u.press(C_ILOFF);
        pm_u.press(C_XSTART);
        tick(1);
        rst <= 1'h1;
        tick(1);
        rst <= 1'h0;
        tick(1);
        reg_read(ADDR_OVT);
        `CHK("ov trip after reset", 32'h00002AF8, d)
        reg_read(ADDR_CTRL);
        `CHK("control after reset", 32'h00000030, d)
        final_report();
    end
endmodule : test_power_fault_supervisor
